// ==== design/eut_pkg.sv ====
package eut_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] COUNT_OFF = 8'h04;
  localparam logic [7:0] PERIOD_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0C;
  localparam logic [7:0] MASK_OFF = 8'h10;

  // ==========================================================
  // Control register field positions
  localparam int DIRSRC_BIT = 0;
  localparam int MODE_LSB = 8;
  localparam int DIR_BIT = 11;
  localparam int SIDL_BIT = 13;

  // ==========================================================
  // Mode encodings and reset values
  localparam logic [2:0] MODE_TIMER = 3'h1;
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam int STAT_MATCH_BIT = 0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : eut_pkg

// ==== design/eut_sync.sv ====
`timescale 1ns/1ns
// Two-flop synchroniser for pin inputs, width parameterised
module eut_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // ==========================================================
  // Two stages, first only feeds second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : eut_sync

// ==== design/eut_timer.sv ====
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module eut_timer (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic phase_a_input,
  input wire logic phase_b_input,
  input wire logic cpu_sleep,
  input wire logic cpu_idle,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ==========================================================
  // State record
  typedef struct packed {
    logic [2:0] mode;
    logic dir;
    logic dirsrc;
    logic sidl;
    logic [15:0] count;
    logic [15:0] period;
    logic status;
    logic mask;
    logic pa_prev;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } eut_state_s;

  eut_state_s st_r;
  eut_state_s st_nxt;

  logic pa_sync;
  logic pb_sync;

  // ==========================================================
  // Pin synchronisers, no asynchronous count path
  eut_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .ce(ce),
    .d({phase_b_input, phase_a_input}),
    .q({pb_sync, pa_sync})
  );

  // ==========================================================
  // Helpers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] ws);
    logic [15:0] res;
    res = old;
    if (ws[0]) begin
      res[7:0] = wd[7:0];
    end
    if (ws[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic addr_ok(input logic [7:0] a);
    return a == eut_pkg::CTRL_OFF || a == eut_pkg::COUNT_OFF ||
           a == eut_pkg::PERIOD_OFF || a == eut_pkg::STATUS_OFF ||
           a == eut_pkg::MASK_OFF;
  endfunction : addr_ok

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic run;
    logic tick;
    logic up;
    logic match;
    logic wr_fire;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [15:0] cval;
    logic [15:0] ctrl_word;
    run = 1'b0;
    tick = 1'b0;
    up = 1'b0;
    match = 1'b0;
    wr_fire = 1'b0;
    wa = 8'h00;
    wd = 32'h0000_0000;
    ws = 4'h0;
    cval = 16'h0000;
    ctrl_word = 16'h0000;
    st_nxt = st_r;

    // Run gating for sleep and idle
    run = !cpu_sleep &&
          !(cpu_idle && st_r.sidl);
    // Rising edge of synchronised phase A
    st_nxt.pa_prev = pa_sync;
    tick = run && (st_r.mode == eut_pkg::MODE_TIMER) &&
           pa_sync && !st_r.pa_prev;
    // Direction sampled at the edge only
    up = st_r.dirsrc ? pb_sync : st_r.dir;

    // Counting with period wrap; count kept across mode changes
    cval = st_r.count;
    if (tick) begin
      if (up) begin
        cval = (st_r.count == st_r.period) ? 16'h0000
               : 16'(st_r.count + 16'h0001);
      end else begin
        cval = (st_r.count == 16'h0000) ? st_r.period
               : 16'(st_r.count - 16'h0001);
      end
      match = (st_r.count == st_r.period);
    end

    // Write address and data captured in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
      st_nxt.wready = 1'b0;
    end
    if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
      wr_fire = 1'b1;
      wa = st_r.aw_addr;
      wd = st_r.w_data;
      ws = st_r.w_strb;
    end

    // Register writes; count write overrides counting
    st_nxt.count = cval;
    if (wr_fire) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = addr_ok(wa) ? eut_pkg::RESP_OKAY
                     : eut_pkg::RESP_SLVERR;
      unique case (wa)
        eut_pkg::CTRL_OFF: begin
          ctrl_word = merge16({2'b00, st_r.sidl, 1'b0, st_r.dir,
                               st_r.mode, 7'h00, st_r.dirsrc}, wd, ws);
          st_nxt.dirsrc = ctrl_word[eut_pkg::DIRSRC_BIT];
          st_nxt.mode = ctrl_word[eut_pkg::MODE_LSB +: 3];
          st_nxt.dir = ctrl_word[eut_pkg::DIR_BIT];
          st_nxt.sidl = ctrl_word[eut_pkg::SIDL_BIT];
        end
        eut_pkg::COUNT_OFF: begin
          st_nxt.count = merge16(st_r.count, wd, ws);
        end
        eut_pkg::PERIOD_OFF: begin
          st_nxt.period = merge16(st_r.period, wd, ws);
        end
        eut_pkg::MASK_OFF: begin
          if (ws[0]) begin
            st_nxt.mask = wd[eut_pkg::STAT_MATCH_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // Sticky match flag, write one clears, set wins
    if (wr_fire && wa == eut_pkg::STATUS_OFF && ws[0] &&
        wd[eut_pkg::STAT_MATCH_BIT]) begin
      st_nxt.status = 1'b0;
    end
    if (match) begin
      st_nxt.status = 1'b1;
    end

    // Write response handshake
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = addr_ok(s_axi_araddr) ? eut_pkg::RESP_OKAY
                     : eut_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        eut_pkg::CTRL_OFF: begin
          st_nxt.rdata = {16'h0000, 2'b00, st_r.sidl, 1'b0, st_r.dir,
                          st_r.mode, 7'h00, st_r.dirsrc};
        end
        eut_pkg::COUNT_OFF: begin
          st_nxt.rdata = {16'h0000, st_r.count};
        end
        eut_pkg::PERIOD_OFF: begin
          st_nxt.rdata = {16'h0000, st_r.period};
        end
        eut_pkg::STATUS_OFF: begin
          st_nxt.rdata = {31'h0, st_r.status};
        end
        eut_pkg::MASK_OFF: begin
          st_nxt.rdata = {31'h0, st_r.mask};
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end

    // Level interrupt registered from next-state flags
    st_nxt.irq = st_nxt.status && st_nxt.mask;
  end

  // ==========================================================
  // State register with reset and clock enable
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.mode <= eut_pkg::MODE_RST;
      st_r.sidl <= 1'b0;
      st_r.count <= eut_pkg::COUNT_RST;
      st_r.period <= eut_pkg::PERIOD_RST;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from flops
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign irq = st_r.irq;

endmodule : eut_timer

// ==== verif/eut_timer_assertions.sv ====
`timescale 1ns/1ns
// ==========================================================
// Handshake checks on the register port
module eut_timer_assertions (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Answers stand until taken, then drop and reopen
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  a_w_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer late");
  a_w_closed: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write port open while answering");
  a_ar_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read port open while answering");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer not released");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
endmodule : eut_timer_assertions

bind eut_timer eut_timer_assertions eut_timer_assertions_i (
  .core_clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);

// ==== verif/eut_pin_model.sv ====
`timescale 1ns/1ns
// ==========================================================
// Pin driver: phase-A count pulses, phase-B direction level
module eut_pin_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic slow,
  input wire logic dir_up,
  input wire logic [7:0] n_pulses,
  output logic phase_a_input,
  output logic phase_b_input,
  output logic busy
);
  logic [11:0] cnt_r = 12'h000;
  // Eight or sixteen cycles per pulse, counted down to idle
  always @(posedge core_clk) begin
    if (go && !busy) begin
      cnt_r <= slow ? {n_pulses, 4'h0} : {1'b0, n_pulses, 3'h0};
    end else if (busy) begin
      cnt_r <= cnt_r - 12'h001;
    end
  end
  // Phase A rests low between bursts
  assign phase_a_input = busy && (slow ? cnt_r[3] : cnt_r[2]);
  assign phase_b_input = dir_up;
  assign busy = cnt_r != 12'h000;
endmodule : eut_pin_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
// ==========================================================
// Timer bench
module tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic cpu_sleep = 1'b0;
  logic cpu_idle = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic dir_up = 1'b0;
  logic [7:0] n_pulses = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, phase_a_input, phase_b_input, busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int err_total = 0;
  int n_tests = 0;
  eut_timer eut_timer_i (.*);
  eut_pin_model eut_pin_model_i (.*);
  // Clock, 40 ns period
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One bus transfer; samples at falling edge, drives after rising
  task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    logic aw, w, ar, rsp;
    rsp = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= we;
    s_axi_wvalid <= we;
    s_axi_bready <= we;
    s_axi_arvalid <= !we;
    s_axi_rready <= !we;
    for (int n = 0; n < 50 && !rsp; n++) begin
      @(negedge core_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      rsp = we ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = we ? s_axi_bresp : s_axi_rresp;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (rsp) s_axi_bready <= 1'b0;
      if (rsp) s_axi_rready <= 1'b0;
    end
    if (!rsp) begin
      err_total++;
      complete_run();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, q, r);
    chk({30'h0, r}, 32'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, a, 32'h0, q, r);
    chk(q, e);
    chk({30'h0, r}, 32'h0);
  endtask : rd
  task automatic irq_is(input logic e);
    repeat (2) @(negedge core_clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask : irq_is
  // Burst of n phase-A pulses, then settle
  task automatic pulses(input logic [7:0] n);
    @(posedge core_clk);
    go <= 1'b1;
    n_pulses <= n;
    @(posedge core_clk);
    go <= 1'b0;
    // Let the model's load settle before watching busy
    @(negedge core_clk);
    for (int k = 0; k < 4000 && busy; k++) @(negedge core_clk);
    if (busy) begin
      err_total++;
      complete_run();
    end
    repeat (4) @(posedge core_clk);
  endtask : pulses
  task automatic t_reset();
    rd(eut_pkg::CTRL_OFF, 32'h0);
    rd(eut_pkg::PERIOD_OFF, 32'h0000_FFFF);
    irq_is(1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_up();
    wr(eut_pkg::PERIOD_OFF, 32'h3);
    wr(eut_pkg::CTRL_OFF, 32'h0000_0900);
    pulses(8'h05);
    rd(eut_pkg::COUNT_OFF, 32'h1);
    rd(eut_pkg::STATUS_OFF, 32'h1);
    wr(eut_pkg::MASK_OFF, 32'h1);
    irq_is(1'b1);
    wr(eut_pkg::STATUS_OFF, 32'h1);
    irq_is(1'b0);
    $display("test up done");
  endtask : t_up
  task automatic t_down();
    wr(eut_pkg::CTRL_OFF, 32'h0000_0100);
    pulses(8'h03);
    rd(eut_pkg::COUNT_OFF, 32'h2);
    irq_is(1'b1);
    wr(eut_pkg::STATUS_OFF, 32'h1);
    wr(eut_pkg::CTRL_OFF, 32'h0000_0101);
    pulses(8'h02);
    rd(eut_pkg::COUNT_OFF, 32'h0);
    dir_up <= 1'b1;
    pulses(8'h03);
    rd(eut_pkg::COUNT_OFF, 32'h3);
    $display("test down done");
  endtask : t_down
  task automatic t_mode();
    wr(eut_pkg::CTRL_OFF, 32'h0000_0800);
    pulses(8'h02);
    rd(eut_pkg::COUNT_OFF, 32'h3);
    wr(eut_pkg::CTRL_OFF, 32'h0000_0900);
    pulses(8'h01);
    rd(eut_pkg::COUNT_OFF, 32'h0);
    $display("test mode done");
  endtask : t_mode
  task automatic t_power();
    cpu_sleep <= 1'b1;
    pulses(8'h02);
    rd(eut_pkg::COUNT_OFF, 32'h0);
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    slow <= 1'b1;
    pulses(8'h02);
    rd(eut_pkg::COUNT_OFF, 32'h2);
    wr(eut_pkg::CTRL_OFF, 32'h0000_2900);
    pulses(8'h02);
    rd(eut_pkg::COUNT_OFF, 32'h2);
    cpu_idle <= 1'b0;
    $display("test power done");
  endtask : t_power
  task automatic t_unmapped();
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, 8'h14, 32'h0000_FFFF, q, r);
    chk({30'h0, r}, {30'h0, eut_pkg::RESP_SLVERR});
    bus(1'b0, 8'h14, 32'h0, q, r);
    chk(q, 32'h0);
    chk({30'h0, r}, {30'h0, eut_pkg::RESP_SLVERR});
    $display("test unmapped done");
  endtask : t_unmapped
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_up();
    t_down();
    t_mode();
    t_power();
    t_unmapped();
    complete_run();
  end
endmodule : tb_top
